// ---- dcf_fifo.sv ----
// Dual-clock 9-bit first-in first-out buffer with mode, offset and level flags
//
// The strobed register port and the register offsets are this design's own decisions.
`include "dcf_cfg.svh"
// How it works
// - Full init zeroes pointers and output word
// - Full init captures mode, default offset, method
// - Partial clear zeroes data, keeps all settings
// - Reread rewinds read pointer, empty flag briefly forced
// - Shared pin: mode at init, serial data after
// - Write strobe stores word or offset part
// - Serial enable with select shifts offset bit
// - Read strobe delivers word or offset part
// - Output enable gates drive, touches nothing else
// - Select picks default at init, gates offsets after
// - Full pin is full or space available
// - Empty pin is empty or word valid
// - Near full low above capacity minus m
// - Near empty low below n
// - Half level flag shows above half
// - Words and locations are 9 bits
// - Select low: 127 parallel; high: 1023 serial
// - Fall-through shows first word after three transitions
// - Depth 65536 words sets thresholds
module dcf_fifo (
   // System
   input  wire logic                sys_clk_i,
   input  wire logic                rst_b_i,
   // Write side
   input  wire logic                wclk_i,
   input  wire logic                write_strobe_enable_b_i,
   input  wire logic [`DCF_WW-1:0]  write_word_in_i,
   input  wire logic                serial_load_enable_b_i,
   input  wire logic                fall_through_select_i,
   // Read side
   input  wire logic                rclk_i,
   input  wire logic                read_strobe_enable_b_i,
   input  wire logic                reread_request_b_i,
   input  wire logic                output_drive_enable_b_i,
   // Control
   input  wire logic                full_init_b_i,
   input  wire logic                partial_clear_b_i,
   input  wire logic                offset_access_select_b_i,
   // Data out
   output logic      [`DCF_WW-1:0]  read_word_out_o,
   output logic                     read_word_out_oe_b_o,
   // Flags
   output logic                     full_o,
   output logic                     empty_o,
   output logic                     near_full_b_o,
   output logic                     near_empty_b_o,
   output logic                     half_level_b_o
);
   import dcf_pkg::*;

   dcf_state_t         st;
   dcf_state_t         nx;
   dcf_mem_if          mif ();
   logic               wrise;
   logic               rrise;
   logic               rtr;
   logic               init_act;
   logic               clr_act;
   logic               ld_act;
   logic               rt_evt;
   logic               rd_off;
   logic [`DCF_PW-1:0] cnt;
   logic [`DCF_WW-1:0] din;

   dcf_mem u_dcf_mem (
      .sys_clk_i (sys_clk_i),
      .mif       (mif.mem)
   );

   // Only the second sampler stage is ever decoded
   assign wrise    = st.s2[`DCF_B_WCLK] & ~st.wclk_q;
   assign rrise    = st.s2[`DCF_B_RCLK] & ~st.rclk_q;
   assign rtr      = st.s2[`DCF_B_RCLK] ^ st.rclk_q;
   assign init_act = ~st.s2[`DCF_B_INIT];
   assign clr_act  = ~st.s2[`DCF_B_CLR];
   assign ld_act   = ~st.s2[`DCF_B_LD];
   assign rt_evt   = rrise & ~st.s2[`DCF_B_RT];
   assign rd_off   = rrise & ~st.s2[`DCF_B_REN] & ld_act;
   assign din      = st.s2[`DCF_B_D +: `DCF_WW];
   assign cnt      = st.wr_ptr - st.rd_ptr;

   assign read_word_out_o      = st.out;
   assign read_word_out_oe_b_o = st.s2[`DCF_B_OE];
   assign full_o               = st.full_pin;
   assign empty_o              = st.empty_pin;
   assign near_full_b_o        = st.nf_b;
   assign near_empty_b_o       = st.ne_b;
   assign half_level_b_o       = st.hf_b;

   always_comb
   begin
      logic [`DCF_PW-1:0] nc;
      nc = '0;
      nx = st;
      nx.s1 = {write_word_in_i, output_drive_enable_b_i, offset_access_select_b_i,
               serial_load_enable_b_i, read_strobe_enable_b_i, write_strobe_enable_b_i,
               reread_request_b_i, partial_clear_b_i, full_init_b_i,
               fall_through_select_i, rclk_i, wclk_i};
      nx.s2 = st.s1;
      nx.wclk_q = st.s2[`DCF_B_WCLK];
      nx.rclk_q = st.s2[`DCF_B_RCLK];
      mif.we = 1'b0;
      mif.wa = st.wr_ptr[`DCF_AW-1:0];
      mif.wd = din;
      mif.re = 1'b0;
      mif.ra = st.rd_ptr[`DCF_AW-1:0];
      if (init_act || clr_act)
      begin
         if (init_act)
         begin
            nx.fall_through_select     = st.s2[`DCF_B_SI];
            nx.ser_mode = st.s2[`DCF_B_LD];
            nx.offs     = st.s2[`DCF_B_LD] ? {`DCF_OFF_HI, `DCF_OFF_HI}
                                           : {`DCF_OFF_LO, `DCF_OFF_LO};
         end
         nx.wr_ptr  = '0;
         nx.rd_ptr  = '0;
         nx.out     = '0;
         nx.rd_st   = DCF_RD_IDLE;
         nx.pidx    = '0;
         nx.ridx    = '0;
         nx.sbit    = '0;
         nx.tcnt    = '0;
         nx.rt_hold = '0;
      end
      else
      begin
         if (wrise && ~st.s2[`DCF_B_WEN])
         begin
            if (ld_act)
            begin
               // Parallel offset load walks n low, n high, m low, m high
               case (st.pidx)
                  2'h0: nx.offs[8:0]   = din;
                  2'h1: nx.offs[15:9]  = din[6:0];
                  2'h2: nx.offs[24:16] = din;
                  default: nx.offs[31:25] = din[6:0];
               endcase
               nx.pidx = st.pidx + 2'h1;
            end
            else if (cnt != `DCF_DEPTH)
            begin
               mif.we    = 1'b1;
               nx.wr_ptr = st.wr_ptr + `DCF_PW'h1;
            end
         end
         if (wrise && ~st.s2[`DCF_B_SEN] && ld_act)
         begin
            nx.offs[st.sbit] = st.s2[`DCF_B_SI];
            nx.sbit = st.sbit + 5'h1;
         end
         if (rrise && st.rt_hold != 2'h0)
         begin
            nx.rt_hold = st.rt_hold - 2'h1;
         end
         if (rt_evt)
         begin
            nx.rd_ptr  = '0;
            nx.rd_st   = DCF_RD_IDLE;
            nx.tcnt    = '0;
            nx.rt_hold = `DCF_RT_HOLD;
         end
         else if (rd_off)
         begin
            case (st.ridx)
               2'h0: nx.out = st.offs[8:0];
               2'h1: nx.out = {2'h0, st.offs[15:9]};
               2'h2: nx.out = st.offs[24:16];
               default: nx.out = {2'h0, st.offs[31:25]};
            endcase
            nx.ridx = st.ridx + 2'h1;
         end
         else
         begin
            case (st.rd_st)
               DCF_RD_IDLE:
               begin
                  if (st.fall_through_select && cnt != '0)
                  begin
                     nx.rd_st = DCF_RD_WAIT;
                     nx.tcnt  = '0;
                  end
                  else if (!st.fall_through_select && rrise && ~st.s2[`DCF_B_REN] && cnt != '0)
                  begin
                     mif.re    = 1'b1;
                     nx.rd_ptr = st.rd_ptr + `DCF_PW'h1;
                     nx.rd_st  = DCF_RD_LOAD;
                  end
               end
               DCF_RD_WAIT:
               begin
                  if (rtr && st.tcnt == `DCF_FT_LAST)
                  begin
                     mif.re    = 1'b1;
                     nx.rd_ptr = st.rd_ptr + `DCF_PW'h1;
                     nx.rd_st  = DCF_RD_LOAD;
                  end
                  else if (rtr)
                  begin
                     nx.tcnt = st.tcnt + 2'h1;
                  end
               end
               DCF_RD_LOAD:
               begin
                  nx.out   = mif.rd;
                  nx.rd_st = st.fall_through_select ? DCF_RD_SHOW : DCF_RD_IDLE;
               end
               DCF_RD_SHOW:
               begin
                  if (rrise && ~st.s2[`DCF_B_REN])
                  begin
                     if (cnt != '0)
                     begin
                        mif.re    = 1'b1;
                        nx.rd_ptr = st.rd_ptr + `DCF_PW'h1;
                        nx.rd_st  = DCF_RD_LOAD;
                     end
                     else
                     begin
                        nx.rd_st = DCF_RD_IDLE;
                     end
                  end
               end
               default: nx.rd_st = DCF_RD_IDLE;
            endcase
         end
      end
      nc = nx.wr_ptr - nx.rd_ptr;
      // Write-side flags move only on write clock edges, init and clear
      if (wrise || init_act || clr_act)
      begin
         nx.full_pin = nx.fall_through_select ? (nc == `DCF_DEPTH) : (nc != `DCF_DEPTH);
         nx.nf_b     = !(nc > (`DCF_DEPTH - {1'b0, nx.offs[31:16]}));
         nx.hf_b     = !(nc > `DCF_HALF);
      end
      if (rrise || init_act || clr_act)
      begin
         nx.ne_b = !(nc < {1'b0, nx.offs[15:0]});
         if (!nx.fall_through_select)
         begin
            nx.empty_pin = (nc != '0) && (nx.rt_hold == 2'h0);
         end
      end
      // Word valid tracks the output stage; its changes only follow read clock edges, init and clear
      if (nx.fall_through_select)
      begin
         nx.empty_pin = (nx.rd_st != DCF_RD_SHOW);
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         st <= '0;
      end
      else
      begin
         st <= nx;
      end
   end

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_b_i);

   sequence s_load_show;
      (st.rd_st == DCF_RD_LOAD) ##1 (st.rd_st == DCF_RD_SHOW && empty_o == 1'b0);
   endsequence

   property p_init_clear;
      init_act |=> (st.wr_ptr == '0 && st.rd_ptr == '0 && read_word_out_o == '0);
   endproperty
   a_init_clear: assert property (p_init_clear) else $error("init left data");

   property p_init_mode;
      init_act |=> (st.fall_through_select == $past(st.s2[`DCF_B_SI]) && st.ser_mode == $past(st.s2[`DCF_B_LD]));
   endproperty
   a_init_mode: assert property (p_init_mode) else $error("mode not captured");

   property p_clear_keeps;
      (clr_act && !init_act) |=> ($stable(st.fall_through_select) && $stable(st.offs) && st.wr_ptr == '0);
   endproperty
   a_clear_keeps: assert property (p_clear_keeps) else $error("clear lost setup");

   property p_reread;
      (rt_evt && !init_act && !clr_act && !st.fall_through_select)
         |=> (st.rd_ptr == '0 && empty_o == 1'b0) ##1 (empty_o == 1'b0);
   endproperty
   a_reread: assert property (p_reread) else $error("reread failed");

   property p_oe_quiet;
      ($changed(read_word_out_oe_b_o) && !wrise && !rrise && st.rd_st == DCF_RD_IDLE)
         |=> ($stable(st.wr_ptr) && $stable(st.rd_ptr) && $stable(empty_o));
   endproperty
   a_oe_quiet: assert property (p_oe_quiet) else $error("enable moved state");

   property p_full_ignore;
      (wrise && !init_act && !clr_act && cnt == `DCF_DEPTH) |=> $stable(st.wr_ptr);
   endproperty
   a_full_ignore: assert property (p_full_ignore) else $error("write when full");

   property p_full_pin;
      (wrise && !init_act && !clr_act)
         |=> (full_o == (st.fall_through_select ? (cnt == `DCF_DEPTH) : (cnt != `DCF_DEPTH)));
   endproperty
   a_full_pin: assert property (p_full_pin) else $error("full pin wrong");

   property p_near_full;
      (wrise && !init_act && !clr_act)
         |=> (near_full_b_o == !(cnt > (`DCF_DEPTH - {1'b0, st.offs[31:16]})));
   endproperty
   a_near_full: assert property (p_near_full) else $error("near full wrong");

   property p_ft_first;
      (st.fall_through_select && st.rd_st == DCF_RD_WAIT && st.tcnt == `DCF_FT_LAST && rtr
       && !init_act && !clr_act && !rt_evt && !rd_off) |=> s_load_show;
   endproperty
   a_ft_first: assert property (p_ft_first) else $error("first word late");
endmodule

// ---- dcf_cfg.svh ----
// Constants of the dual-clock buffer: sizes, offsets, counts and sampler bit positions
`ifndef DCF_CFG_SVH
`define DCF_CFG_SVH
`define DCF_WW       9
`define DCF_AW       16
`define DCF_PW       17
`define DCF_DEPTH    17'h10000
`define DCF_HALF     17'h08000
`define DCF_OFF_LO   16'h007f
`define DCF_OFF_HI   16'h03ff
`define DCF_FT_LAST  2'h2
`define DCF_RT_HOLD  2'h2
`define DCF_SW       20
`define DCF_B_WCLK   0
`define DCF_B_RCLK   1
`define DCF_B_SI     2
`define DCF_B_INIT   3
`define DCF_B_CLR    4
`define DCF_B_RT     5
`define DCF_B_WEN    6
`define DCF_B_REN    7
`define DCF_B_SEN    8
`define DCF_B_LD     9
`define DCF_B_OE     10
`define DCF_B_D      11
`endif

// ---- dcf_pkg.sv ----
// Types of the dual-clock buffer
`include "dcf_cfg.svh"
package dcf_pkg;
   typedef enum logic [1:0] {DCF_RD_IDLE, DCF_RD_WAIT, DCF_RD_LOAD, DCF_RD_SHOW} dcf_rd_t;
   typedef struct packed {
      logic [`DCF_SW-1:0] s1;
      logic [`DCF_SW-1:0] s2;
      logic               wclk_q;
      logic               rclk_q;
      logic               fall_through_select;
      logic               ser_mode;
      logic [31:0]        offs;
      logic [1:0]         pidx;
      logic [1:0]         ridx;
      logic [4:0]         sbit;
      logic [`DCF_PW-1:0] wr_ptr;
      logic [`DCF_PW-1:0] rd_ptr;
      dcf_rd_t            rd_st;
      logic [1:0]         tcnt;
      logic [1:0]         rt_hold;
      logic [`DCF_WW-1:0] out;
      logic               full_pin;
      logic               empty_pin;
      logic               nf_b;
      logic               ne_b;
      logic               hf_b;
   } dcf_state_t;
endpackage

// ---- dcf_mem_if.sv ----
// Port between the buffer control and its storage array
`include "dcf_cfg.svh"
interface dcf_mem_if;
   logic               we;
   logic [`DCF_AW-1:0] wa;
   logic [`DCF_WW-1:0] wd;
   logic               re;
   logic [`DCF_AW-1:0] ra;
   logic [`DCF_WW-1:0] rd;
   modport ctrl (output we, wa, wd, re, ra, input rd);
   modport mem  (input we, wa, wd, re, ra, output rd);
endinterface

// ---- dcf_mem.sv ----
// Storage array of the buffer with registered read data
`include "dcf_cfg.svh"
module dcf_mem (
   // Clock
   input  wire logic sys_clk_i,
   // Array port
   dcf_mem_if.mem    mif
);
   import dcf_pkg::*;

   logic [`DCF_WW-1:0] ram [0:`DCF_DEPTH-1];

   always_ff @(posedge sys_clk_i)
   begin
      if (mif.we)
      begin
         ram[mif.wa] <= mif.wd;
      end
      if (mif.re)
      begin
         mif.rd <= ram[mif.ra];
      end
   end
endmodule

// ---- dcf_peer.sv ----
// Writer and reader model that clocks words and offsets through the buffer
`include "dcf_cfg.svh"
module dcf_peer (
   // System
   input  wire logic               sys_clk_i,
   // Write side
   output logic                    wclk_o,
   output logic                    wen_b_o,
   output logic                    sen_b_o,
   output logic [`DCF_WW-1:0]      wd_o,
   // Read side
   output logic                    rclk_o,
   output logic                    ren_b_o,
   output logic                    rt_b_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      wclk_o = 1'b0;
      wen_b_o = 1'b1;
      sen_b_o = 1'b1;
      wd_o = 9'h000;
      rclk_o = 1'b0;
      ren_b_o = 1'b1;
      rt_b_o = 1'b1;
   end
   // Clocks stand still between transfers; released data inverts so stale words never match
   task automatic wtick(input logic wen_b, input logic sen_b, input logic [8:0] d);
      @(posedge sys_clk_i);
      wen_b_o <= wen_b;
      sen_b_o <= sen_b;
      wd_o <= d;
      repeat (4) @(posedge sys_clk_i);
      wclk_o <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      wclk_o <= 1'b0;
      wen_b_o <= 1'b1;
      sen_b_o <= 1'b1;
      wd_o <= ~d;
   endtask
   task automatic rtick(input logic ren_b, input logic rt_b);
      @(posedge sys_clk_i);
      ren_b_o <= ren_b;
      rt_b_o <= rt_b;
      repeat (4) @(posedge sys_clk_i);
      rclk_o <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      rclk_o <= 1'b0;
      ren_b_o <= 1'b1;
      rt_b_o <= 1'b1;
   endtask
endmodule

// ---- dcf_fifo_tb.sv ----
// Self-checking bench of the dual-clock buffer
`include "dcf_cfg.svh"
module dcf_fifo_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk_i = 1'b0, rst_b_i = 1'b0, init_b = 1'b1, clr_b = 1'b1, sel_b = 1'b0;
   logic oe_b = 1'b0, ft = 1'b0, wclk, wen_b, sen_b, rclk, ren_b, rt_b;
   logic [8:0] wd, q, w [3], ov [4];
   logic oeb_o, full_o, empty_o, nf_b, ne_b, hf_b;
   int bad_count = 0, n_tests = 0;
   initial
   begin
      forever #50 sys_clk_i = ~sys_clk_i;
   end
   dcf_peer u_dcf_peer (.sys_clk_i(sys_clk_i), .wclk_o(wclk), .wen_b_o(wen_b),
      .sen_b_o(sen_b), .wd_o(wd), .rclk_o(rclk), .ren_b_o(ren_b), .rt_b_o(rt_b));
   dcf_fifo u_dcf_fifo (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .wclk_i(wclk),
      .write_strobe_enable_b_i(wen_b), .write_word_in_i(wd), .serial_load_enable_b_i(sen_b),
      .fall_through_select_i(ft), .rclk_i(rclk), .read_strobe_enable_b_i(ren_b),
      .reread_request_b_i(rt_b), .output_drive_enable_b_i(oe_b), .full_init_b_i(init_b),
      .partial_clear_b_i(clr_b), .offset_access_select_b_i(sel_b), .read_word_out_o(q),
      .read_word_out_oe_b_o(oeb_o), .full_o(full_o), .empty_o(empty_o),
      .near_full_b_o(nf_b), .near_empty_b_o(ne_b), .half_level_b_o(hf_b));
   task automatic results();
      if (bad_count == 0 && n_tests > 0)
      begin
         $display("NO MISMATCHES");
      end
      else
      begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("ERROR %0t saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic chkf(input logic seen, input logic exp);
      chk({8'h00, seen}, {8'h00, exp});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask
   task automatic rd_chk(input logic [8:0] exp);
      u_dcf_peer.rtick(1'b0, 1'b1);
      cyc(4);
      chk(q, exp);
   endtask
   // Mode pin and select are held well past the synchroniser so the capture cannot miss them
   task automatic init(input logic mode, input logic sel);
      init_b <= 1'b0;
      ft <= mode;
      sel_b <= sel;
      cyc(6);
      init_b <= 1'b1;
      cyc(6);
      ft <= 1'b0;
      sel_b <= 1'b1;
      cyc(2);
   endtask
   task automatic t_std();
      init(1'b0, 1'b0);
      chk(q, 9'h000);
      chkf(empty_o, 1'b0);
      chkf(full_o, 1'b1);
      chkf(ne_b, 1'b0);
      chkf(nf_b, 1'b1);
      chkf(hf_b, 1'b1);
      foreach (w[i]) u_dcf_peer.wtick(1'b0, 1'b1, w[i]);
      // Empty flag only follows read clock edges, so give it one idle read edge
      u_dcf_peer.rtick(1'b1, 1'b1);
      cyc(6);
      chkf(empty_o, 1'b1);
      foreach (w[i]) rd_chk(w[i]);
      chkf(empty_o, 1'b0);
      rd_chk(w[2]);
   endtask
   task automatic t_reread();
      u_dcf_peer.rtick(1'b1, 1'b0);
      cyc(2);
      chkf(empty_o, 1'b0);
      u_dcf_peer.rtick(1'b1, 1'b1);
      u_dcf_peer.rtick(1'b1, 1'b1);
      cyc(4);
      chkf(empty_o, 1'b1);
      rd_chk(w[0]);
   endtask
   task automatic t_offs();
      sel_b <= 1'b0;
      cyc(2);
      foreach (ov[i]) u_dcf_peer.wtick(1'b0, 1'b1, ov[i]);
      foreach (ov[i]) rd_chk(ov[i]);
      sel_b <= 1'b1;
      cyc(4);
      chkf(ne_b, 1'b1);
      rd_chk(w[1]);
      chkf(ne_b, 1'b0);
   endtask
   task automatic t_oe_clear();
      oe_b <= 1'b1;
      cyc(5);
      chkf(oeb_o, 1'b1);
      chkf(empty_o, 1'b1);
      oe_b <= 1'b0;
      cyc(5);
      chkf(oeb_o, 1'b0);
      clr_b <= 1'b0;
      cyc(6);
      clr_b <= 1'b1;
      cyc(6);
      chk(q, 9'h000);
      chkf(empty_o, 1'b0);
      sel_b <= 1'b0;
      rd_chk(ov[0]);
      sel_b <= 1'b1;
   endtask
   task automatic t_fall_through_select();
      logic [31:0] sn;
      sn = {16'h0007, 16'h0005};
      init(1'b1, 1'b1);
      sel_b <= 1'b0;
      for (int i = 0; i < 4; i++) rd_chk(i[0] ? 9'h001 : 9'h1ff);
      for (int i = 0; i < 32; i++)
      begin
         ft <= sn[i];
         u_dcf_peer.wtick(1'b1, 1'b0, 9'h000);
      end
      for (int i = 0; i < 4; i++) rd_chk(i[0] ? 9'h000 : (i[1] ? 9'h007 : 9'h005));
      sel_b <= 1'b1;
      u_dcf_peer.wtick(1'b0, 1'b1, 9'h0c3);
      cyc(4);
      chkf(empty_o, 1'b1);
      chkf(full_o, 1'b0);
      u_dcf_peer.rtick(1'b1, 1'b1);
      u_dcf_peer.rtick(1'b1, 1'b1);
      cyc(6);
      chk(q, 9'h0c3);
      chkf(empty_o, 1'b0);
   endtask
   initial
   begin
      cyc(90000);
      bad_count++;
      results();
   end
   initial
   begin
      w = '{9'h1a5, 9'h05a, 9'h100};
      ov = '{9'h002, 9'h000, 9'h003, 9'h000};
      cyc(12);
      rst_b_i <= 1'b1;
      cyc(2);
      t_std();
      t_reread();
      t_offs();
      t_oe_clear();
      t_fall_through_select();
      results();
   end
endmodule
